// [hiop_pkg.sv]
// handler i/o port bank: register map, field layout and reset values
// assumes a 32-bit apb slave with one aligned word per register
// Functional notes
// - output port two is 8 bits, value bit 0 on pin 0, bit 7 on pin 7.
// - with strobe route on, written bit 6 is ignored; pin 6 shows strobe.
// - with trigger-ready route on, written bit 7 ignored; pin 7 shows ready.
// - first nibble port in output mode drives its pins from written value.
// - first nibble port in input mode reads back its pin levels.
// - first nibble maps value bit 0 to pin 0, bit 3 to pin 3.
// - first nibble direction is readable and writable, input after reset.
// - second nibble drives pins in output mode, reads pins in input mode.
// - second nibble maps value bit 0 to pin 0, bit 3 to pin 3.
// - second nibble has its own direction setting, input after reset.
// - combined byte view: first nibble bits 0-3, second nibble bits 4-7.
// - combined byte view in input mode reads all eight pin levels.
// - 16-bit write sets port one from bits 0-7, port two from 8-15.
// - with strobe route on, bit 14 of the 16-bit write is ignored.
// - with trigger-ready route on, bit 15 of the 16-bit write is ignored.
// - strobe route enable onto port two pin 6, readable, off after reset.
// - two single-bit output terminals, writable and readable back.
// - output port one is 8 bits, value bit 0 on pin 0, bit 7 on pin 7.
// - trigger-ready route enable onto port two pin 7, readable, off at reset.
package hiop_pkg;
  localparam logic [7:0] ADDR_PORT_ONE = 8'h00;
  localparam logic [7:0] ADDR_PORT_TWO = 8'h04;
  localparam logic [7:0] ADDR_NIB_FIRST = 8'h08;
  localparam logic [7:0] ADDR_NIB_SECOND = 8'h0c;
  localparam logic [7:0] ADDR_NIB_BOTH = 8'h10;
  localparam logic [7:0] ADDR_PORT_WIDE = 8'h14;
  localparam logic [7:0] ADDR_CONTROL = 8'h18;
  localparam logic [7:0] ADDR_AUX_OUT = 8'h1c;
  // control register fields
  localparam int CTL_FIRST_DIR = 0;
  localparam int CTL_SECOND_DIR = 1;
  localparam int CTL_STROBE_EN = 2;
  localparam int CTL_READY_EN = 3;
  localparam int CTL_WIDTH = 4;
  // aux output register fields
  localparam int AUX_FIRST = 0;
  localparam int AUX_SECOND = 1;
  localparam int AUX_WIDTH = 2;
  localparam int STROBE_PIN = 6;
  localparam int READY_PIN = 7;
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam logic [3:0] NIB_RESET = 4'h0;
  localparam logic [3:0] CTL_RESET = 4'h0;
  localparam logic [1:0] AUX_RESET = 2'h0;
  localparam logic DIR_INPUT = 1'b0;
  localparam logic DIR_OUTPUT = 1'b1;
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_ACCESS} hiop_apb_st_t;
endpackage

// [hiop_nib_if.sv]
// hiop_nib_if: one nibble port between the bank and its pad driver
// assumes both sides run on the same clock
`timescale 1ns/1ns
`default_nettype none
interface hiop_nib_if;
  logic [3:0] value;
  logic dirOut;
  logic [3:0] pinIn;
  logic [3:0] pinOut;
  logic [3:0] pinOe;
  logic [3:0] readBack;
  modport bank (output value, output dirOut, input readBack);
  modport pad (input value, input dirOut, input pinIn, output pinOut, output pinOe, output readBack);
endinterface
`default_nettype wire

// [hiop_nibble_port.sv]
// hiop_nibble_port: registered pad drive and combinational read-back for one 4-bit port
// assumes pin inputs are synchronous to clk
`timescale 1ns/1ns
`default_nettype none
module hiop_nibble_port (
  input wire logic clk,
  input wire logic rst,
  hiop_nib_if.pad nib
);
  // pins driven only in output mode; bit i of value on pin i
  always_ff @(posedge clk) begin
    if (rst) begin
      nib.pinOut <= hiop_pkg::NIB_RESET;
      nib.pinOe <= hiop_pkg::NIB_RESET;
    end else begin
      nib.pinOut <= nib.value;
      nib.pinOe <= {4{nib.dirOut}};
    end
  end

  // output mode reads stored value, input mode reads the pins
  always_comb begin
    if (nib.dirOut == hiop_pkg::DIR_OUTPUT) begin
      nib.readBack = nib.value;
    end else begin
      nib.readBack = nib.pinIn;
    end
  end
endmodule
`default_nettype wire

// [hiop_handler_io_port_bank.sv]
// hiop_handler_io_port_bank: apb slave and pin logic for the handler port bank
// assumes a synchronous apb master on clk; pin inputs already synchronous
`timescale 1ns/1ns
`default_nettype none
module hiop_handler_io_port_bank (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic measEndStrobe,
  input wire logic triggerReady,
  output logic [7:0] portOnePins,
  output logic [7:0] portTwoPins,
  input wire logic [3:0] firstNibPinIn,
  output logic [3:0] firstNibPinOut,
  output logic [3:0] firstNibPinOe,
  input wire logic [3:0] secondNibPinIn,
  output logic [3:0] secondNibPinOut,
  output logic [3:0] secondNibPinOe,
  output logic auxOutputFirst,
  output logic auxOutputSecond
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0] portOne;
  logic [7:0] portTwo;
  logic [hiop_pkg::CTL_WIDTH-1:0] control;
  logic [hiop_pkg::AUX_WIDTH-1:0] auxOut;
  logic [31:0] next_prdata;
  logic accessNow;
  logic writeNow;
  logic strobeRouteEnable;
  logic readyRouteEnable;
  hiop_nib_if firstNib ();
  hiop_nib_if secondNib ();
  logic [3:0] firstValue;
  logic [3:0] secondValue;

  assign strobeRouteEnable = control[hiop_pkg::CTL_STROBE_EN];
  assign readyRouteEnable = control[hiop_pkg::CTL_READY_EN];
  // one wait state: pready rises the cycle after the access phase begins
  assign accessNow = psel && penable && !pready;
  assign writeNow = accessNow && pwrite;

  function automatic logic isMapped(input logic [7:0] addr);
    isMapped = (addr == hiop_pkg::ADDR_PORT_ONE) || (addr == hiop_pkg::ADDR_PORT_TWO) ||
      (addr == hiop_pkg::ADDR_NIB_FIRST) || (addr == hiop_pkg::ADDR_NIB_SECOND) ||
      (addr == hiop_pkg::ADDR_NIB_BOTH) || (addr == hiop_pkg::ADDR_PORT_WIDE) ||
      (addr == hiop_pkg::ADDR_CONTROL) || (addr == hiop_pkg::ADDR_AUX_OUT);
  endfunction

  // ----------------------------------------
  // apb handshake
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= accessNow;
      pslverr <= accessNow && !isMapped(paddr);
      prdata <= accessNow ? next_prdata : 32'h0;
    end
  end

  // ----------------------------------------
  // writable registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      portOne <= hiop_pkg::PORT_RESET;
      portTwo <= hiop_pkg::PORT_RESET;
    end else if (writeNow) begin
      if (paddr == hiop_pkg::ADDR_PORT_ONE) begin
        portOne <= pwdata[7:0];
      end
      if (paddr == hiop_pkg::ADDR_PORT_TWO) begin
        portTwo <= pwdata[7:0];
      end
      if (paddr == hiop_pkg::ADDR_PORT_WIDE) begin
        portOne <= pwdata[7:0];
        portTwo <= pwdata[15:8];
      end
    end
  end

  // first and second nibble values, kept across direction changes
  always_ff @(posedge clk) begin
    if (rst) begin
      firstValue <= hiop_pkg::NIB_RESET;
      secondValue <= hiop_pkg::NIB_RESET;
    end else if (writeNow) begin
      if (paddr == hiop_pkg::ADDR_NIB_FIRST) begin
        firstValue <= pwdata[3:0];
      end
      if (paddr == hiop_pkg::ADDR_NIB_SECOND) begin
        secondValue <= pwdata[3:0];
      end
      if (paddr == hiop_pkg::ADDR_NIB_BOTH) begin
        firstValue <= pwdata[3:0];
        secondValue <= pwdata[7:4];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      control <= hiop_pkg::CTL_RESET;
    end else if (writeNow && paddr == hiop_pkg::ADDR_CONTROL) begin
      control <= pwdata[hiop_pkg::CTL_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      auxOut <= hiop_pkg::AUX_RESET;
    end else if (writeNow && paddr == hiop_pkg::ADDR_AUX_OUT) begin
      auxOut <= pwdata[hiop_pkg::AUX_WIDTH-1:0];
    end
  end

  // ----------------------------------------
  // nibble ports
  // ----------------------------------------
  assign firstNib.value = firstValue;
  assign firstNib.dirOut = control[hiop_pkg::CTL_FIRST_DIR];
  assign firstNib.pinIn = firstNibPinIn;
  assign firstNibPinOut = firstNib.pinOut;
  assign firstNibPinOe = firstNib.pinOe;
  assign secondNib.value = secondValue;
  assign secondNib.dirOut = control[hiop_pkg::CTL_SECOND_DIR];
  assign secondNib.pinIn = secondNibPinIn;
  assign secondNibPinOut = secondNib.pinOut;
  assign secondNibPinOe = secondNib.pinOe;

  hiop_nibble_port firstPort (
    .clk(clk),
    .rst(rst),
    .nib(firstNib.pad)
  );

  hiop_nibble_port secondPort (
    .clk(clk),
    .rst(rst),
    .nib(secondNib.pad)
  );

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb begin
    next_prdata = 32'h0;
    unique case (paddr)
      hiop_pkg::ADDR_PORT_ONE: next_prdata[7:0] = portOne;
      hiop_pkg::ADDR_PORT_TWO: next_prdata[7:0] = portTwo;
      hiop_pkg::ADDR_NIB_FIRST: next_prdata[3:0] = firstNib.readBack;
      hiop_pkg::ADDR_NIB_SECOND: next_prdata[3:0] = secondNib.readBack;
      hiop_pkg::ADDR_NIB_BOTH: next_prdata[7:0] = {secondNib.readBack, firstNib.readBack};
      hiop_pkg::ADDR_PORT_WIDE: next_prdata[15:0] = {portTwo, portOne};
      hiop_pkg::ADDR_CONTROL: next_prdata[hiop_pkg::CTL_WIDTH-1:0] = control;
      hiop_pkg::ADDR_AUX_OUT: next_prdata[hiop_pkg::AUX_WIDTH-1:0] = auxOut;
      default: next_prdata = 32'h0;
    endcase
  end

  // ----------------------------------------
  // output pins
  // ----------------------------------------
  // stored bits 6 and 7 are kept; routing only overrides the pin, so
  // turning a route off shows the last written data again
  always_ff @(posedge clk) begin
    if (rst) begin
      portOnePins <= hiop_pkg::PORT_RESET;
      portTwoPins <= hiop_pkg::PORT_RESET;
      auxOutputFirst <= 1'b0;
      auxOutputSecond <= 1'b0;
    end else begin
      portOnePins <= portOne;
      portTwoPins <= portTwo;
      if (strobeRouteEnable) begin
        portTwoPins[hiop_pkg::STROBE_PIN] <= measEndStrobe;
      end
      if (readyRouteEnable) begin
        portTwoPins[hiop_pkg::READY_PIN] <= triggerReady;
      end
      auxOutputFirst <= auxOut[hiop_pkg::AUX_FIRST];
      auxOutputSecond <= auxOut[hiop_pkg::AUX_SECOND];
    end
  end
endmodule
`default_nettype wire

// [hiop_properties.sv]
// hiop_properties: port-level checks of the handler port bank
// assumes a bind onto the top module and one wait state per apb access
`timescale 1ns/1ns
`default_nettype none
module hiop_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] portOnePins,
  input wire logic [3:0] firstNibPinIn,
  input wire logic [3:0] firstNibPinOut,
  input wire logic [3:0] firstNibPinOe,
  input wire logic [3:0] secondNibPinOut,
  input wire logic [3:0] secondNibPinOe,
  input wire logic auxOutputFirst
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // write lands at the access edge, pins follow one edge later and are sampled two edges later
  // ----------------------------------------
  logic wrEdge;
  assign wrEdge = psel && penable && pwrite && !pready;
  AST_PORT_ONE: assert property (wrEdge && paddr == hiop_pkg::ADDR_PORT_ONE |-> ##2
    portOnePins == $past(pwdata[7:0], 2)) else $error("port one pins differ from write");
  AST_WIDE_LOW: assert property (wrEdge && paddr == hiop_pkg::ADDR_PORT_WIDE |-> ##2
    portOnePins == $past(pwdata[7:0], 2)) else $error("wide write low byte not on port one");
  AST_NIB_FIRST: assert property (wrEdge && paddr == hiop_pkg::ADDR_NIB_FIRST |-> ##2
    firstNibPinOut == $past(pwdata[3:0], 2)) else $error("first nibble drive wrong");
  AST_NIB_BOTH: assert property (wrEdge && paddr == hiop_pkg::ADDR_NIB_BOTH |-> ##2
    {secondNibPinOut, firstNibPinOut} == $past(pwdata[7:0], 2)) else $error("byte view drive wrong");
  AST_DIR_FIRST: assert property (wrEdge && paddr == hiop_pkg::ADDR_CONTROL |-> ##2
    firstNibPinOe == {4{$past(pwdata[0], 2)}}) else $error("first nibble enable wrong");
  AST_DIR_SECOND: assert property (wrEdge && paddr == hiop_pkg::ADDR_CONTROL |-> ##2
    secondNibPinOe == {4{$past(pwdata[1], 2)}}) else $error("second nibble enable wrong");
  AST_AUX: assert property (wrEdge && paddr == hiop_pkg::ADDR_AUX_OUT |-> ##2
    auxOutputFirst == $past(pwdata[0], 2)) else $error("aux output wrong");
  AST_READ_PINS: assert property (pready && !pwrite && paddr == hiop_pkg::ADDR_NIB_FIRST
    && $past(firstNibPinOe) == 4'h0 |-> prdata[3:0] == $past(firstNibPinIn)) else $error("pin read wrong");
  cover property (wrEdge && paddr == hiop_pkg::ADDR_CONTROL && pwdata[3:0] == 4'hf);
  cover property (pready && pslverr);
  cover property (pready && !pwrite && paddr == hiop_pkg::ADDR_NIB_BOTH);
endmodule
bind hiop_handler_io_port_bank hiop_properties i_props (.clk, .rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .portOnePins, .firstNibPinIn, .firstNibPinOut, .firstNibPinOe,
  .secondNibPinOut, .secondNibPinOe, .auxOutputFirst);
`default_nettype wire

// [hiop_handler_model.sv]
// hiop_handler_model: component handler on the nibble pins
// assumes bank enables are active high; released pins show the handler level
`timescale 1ns/1ns
`default_nettype none
module hiop_handler_model (
  input wire logic [3:0] firstOut,
  input wire logic [3:0] firstOe,
  input wire logic [3:0] secondOut,
  input wire logic [3:0] secondOe,
  input wire logic [7:0] drive,
  output logic [3:0] firstPin,
  output logic [3:0] secondPin
);
  // a driven bit wins over the handler, so no contention is modelled
  assign firstPin = (firstOe & firstOut) | (~firstOe & drive[3:0]);
  assign secondPin = (secondOe & secondOut) | (~secondOe & drive[7:4]);
endmodule
`default_nettype wire

// [tb.sv]
// tb: random apb traffic against an integer model of the port bank
// assumes one apb slave and the handler model on the nibble pins
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, measEndStrobe, triggerReady;
  logic auxOutputFirst, auxOutputSecond, rerr;
  logic [7:0] paddr, portOnePins, portTwoPins, hv, a;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] firstNibPinIn, firstNibPinOut, firstNibPinOe, secondNibPinIn, secondNibPinOut, secondNibPinOe;
  int mismatches, n_compared, p1, p2, nf, ns, ctl, aux, i;
  hiop_handler_io_port_bank i_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .measEndStrobe, .triggerReady, .portOnePins, .portTwoPins, .firstNibPinIn,
    .firstNibPinOut, .firstNibPinOe, .secondNibPinIn, .secondNibPinOut, .secondNibPinOe,
    .auxOutputFirst, .auxOutputSecond);
  hiop_handler_model i_hdl (.firstOut(firstNibPinOut), .firstOe(firstNibPinOe), .secondOut(secondNibPinOut),
    .secondOe(secondNibPinOe), .drive(hv), .firstPin(firstNibPinIn), .secondPin(secondNibPinIn));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ----------------------------------------
  // apb master and model
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] dd);
    int n;
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= ad; pwdata <= dd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [31:0] expRd(input logic [7:0] ad);
    case (ad)
      hiop_pkg::ADDR_PORT_ONE: expRd = p1;
      hiop_pkg::ADDR_PORT_TWO: expRd = p2;
      hiop_pkg::ADDR_NIB_FIRST: expRd = ctl[0] ? nf : hv[3:0];
      hiop_pkg::ADDR_NIB_SECOND: expRd = ctl[1] ? ns : hv[7:4];
      hiop_pkg::ADDR_NIB_BOTH: expRd = {ctl[1] ? ns[3:0] : hv[7:4], ctl[0] ? nf[3:0] : hv[3:0]};
      hiop_pkg::ADDR_PORT_WIDE: expRd = {p2[7:0], p1[7:0]};
      hiop_pkg::ADDR_CONTROL: expRd = ctl;
      hiop_pkg::ADDR_AUX_OUT: expRd = aux;
      default: expRd = 32'h0;
    endcase
  endfunction
  task automatic rd(input logic [7:0] ad);
    xfer(1'b0, ad, 32'h0);
    chk("read", {rerr, rdat}, {ad > hiop_pkg::ADDR_AUX_OUT, expRd(ad)});
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] dd);
    xfer(1'b1, ad, dd);
    chk("werr", rerr, ad > hiop_pkg::ADDR_AUX_OUT);
    case (ad)
      hiop_pkg::ADDR_PORT_ONE: p1 = dd[7:0];
      hiop_pkg::ADDR_PORT_TWO: p2 = dd[7:0];
      hiop_pkg::ADDR_NIB_FIRST: nf = dd[3:0];
      hiop_pkg::ADDR_NIB_SECOND: ns = dd[3:0];
      hiop_pkg::ADDR_NIB_BOTH: begin nf = dd[3:0]; ns = dd[7:4]; end
      hiop_pkg::ADDR_PORT_WIDE: begin p1 = dd[7:0]; p2 = dd[15:8]; end
      hiop_pkg::ADDR_CONTROL: ctl = dd[3:0];
      hiop_pkg::ADDR_AUX_OUT: aux = dd[1:0];
      default: ;
    endcase
    // pins follow the register one cycle later
    @(negedge clk);
    chk("portOne", portOnePins, p1);
    chk("portTwo", portTwoPins, {ctl[3] ? triggerReady : p2[7], ctl[2] ? measEndStrobe : p2[6], p2[5:0]});
    chk("first", {firstNibPinOe, firstNibPinOut}, {{4{ctl[0]}}, nf[3:0]});
    chk("second", {secondNibPinOe, secondNibPinOut}, {{4{ctl[1]}}, ns[3:0]});
    chk("aux", {auxOutputSecond, auxOutputFirst}, aux[1:0]);
  endtask
  task end_sim();
    if (mismatches == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    measEndStrobe = 1'b0; triggerReady = 1'b0; hv = 8'h00;
    mismatches = 0; n_compared = 0; p1 = 0; p2 = 0; nf = 0; ns = 0; ctl = 0; aux = 0;
    void'($urandom(32'h3a95));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 9; i++) begin
      rd(8'(i * 4));
    end
    // random strobe levels also exercise writes that break the pin 6 advice
    for (i = 0; i < 120; i++) begin
      @(posedge clk);
      hv <= 8'($urandom);
      measEndStrobe <= 1'($urandom);
      triggerReady <= 1'($urandom);
      a = 8'($urandom_range(8, 0) * 4);
      wr(a, $urandom);
      rd(8'($urandom_range(8, 0) * 4));
    end
    end_sim();
  end
  initial begin
    #40000;
    mismatches++;
    end_sim();
  end
endmodule
`default_nettype wire
